// ===== hdl/buck_channel_consts.vh
// constants for the second buck channel set point register bank
`ifndef BUCK_CHANNEL_CONSTS_VH
`define BUCK_CHANNEL_CONSTS_VH
`define ADDR_NORMAL      8'h35
`define ADDR_STANDBY     8'h36
`define ADDR_SLEEP       8'h37
`define ADDR_MODE        8'h38
`define ADDR_CONFIG      8'h39
`define RST_SETPOINT     6'h00
`define RST_MODE         4'h8
`define RST_BIT          1'b0
`define RST_CONFIG       8'h00
`define SP_MSB           5
`define RANGE_BIT        6
`define MODE_MSB         3
`define SLEEP_STATE_BIT  5
`define HI_MAX_CODE      7'h72
`define LO_MIN_CODE      7'h09
`define STATE_NORMAL     2'h0
`define STATE_STANDBY    2'h1
`define STATE_SLEEP      2'h2
`endif

// ===== hdl/setpoint_slot.v
// one set point register with reserved code screening
`timescale 1ns/10ps
`default_nettype none
`include "buck_channel_consts.vh"
module setpoint_slot (
  input  wire       clk,
  input  wire       sys_rst,
  input  wire       wrEn,
  input  wire [5:0] wrData,
  input  wire       rangeHigh,
  output reg  [5:0] stored_ff,
  output reg  [5:0] applied_ff
);
  wire [6:0] code;
  wire       reservedCode;
  assign code = {rangeHigh, wrData};
  // high range tops out, low range bottom codes unusable
  assign reservedCode = rangeHigh ? (code > `HI_MAX_CODE) : (code < `LO_MIN_CODE); // [R16]
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      stored_ff  <= `RST_SETPOINT;
      applied_ff <= `RST_SETPOINT;
    end else if (wrEn) begin
      stored_ff <= wrData;
      // reserved code stored but not passed on to the regulator
      if (!reservedCode) begin // [R21]
        applied_ff <= wrData; // [R15] [R17] [R20]
      end
    end
  end
endmodule
`default_nettype wire

// ===== hdl/cfg_slot.v
// generic control field register of parameterised width (used at 4, 1 and 8 bits)
`timescale 1ns/10ps
`default_nettype none
module cfg_slot #(
  parameter WIDTH = 8,
  parameter [WIDTH-1:0] RESET_VALUE = {WIDTH{1'b0}}
) (
  input  wire             clk,
  input  wire             sys_rst,
  input  wire             wrEn,
  input  wire [WIDTH-1:0] wrData,
  output reg  [WIDTH-1:0] value_ff
);
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      value_ff <= RESET_VALUE;
    end else if (wrEn) begin
      value_ff <= wrData;
    end
  end
endmodule
`default_nettype wire

// ===== hdl/buck_channel_setpoint_regs.v
// register bank of the second buck channel
// Function
// [R1] normal set point bits 5:0 read/write, reset zero
// [R2] normal bit 6 read-only range bit from factory configuration
// [R3] standby set point bits 5:0 read/write, reset zero
// [R4] standby bit 6 mirrors factory range bit
// [R5] sleep set point bits 5:0 read/write, reset zero
// [R6] sleep bit 6 mirrors factory range bit
// [R7] bit 7 of set point registers reads zero
// [R8] mode selector bits 3:0 read/write, reset eight
// [R9] mode bit 5 picks sleep state: off or pulse frequency mode
// [R10] config bit 0 current limit: 0 high, 1 low
// [R11] config bits 3:2 switching frequency selector, reset zero
// [R12] config bits 5:4 phase clock selection, reset zero
// [R13] config bits 7:6 voltage scaling speed, reset zero
// [R14] config bit 1 unused but read/write, reset zero
// [R15] high range codes step 50 mV, top code 3.3 V
// [R16] high codes above top are reserved, never applied
// [R17] low range codes step 25 mV
// [R18] registers at addresses 0x35 to 0x39
// [R19] applied set point follows current operating state
// [R20] low codes 0 to 8 reserved, code 9 is minimum
// [R21] reserved code stored but previous valid target kept
`timescale 1ns/10ps
`default_nettype none
`include "buck_channel_consts.vh"
module buck_channel_setpoint_regs (
  input  wire       clk,
  input  wire       sys_rst,
  input  wire       rangeOtp,
  input  wire [1:0] opState,
  input  wire       regWr,
  input  wire       regRd,
  input  wire [7:0] regAddr,
  input  wire [7:0] regWrData,
  output reg  [7:0] regRdData_ff,
  output reg        regHit_ff,
  output reg  [6:0] targetCode_ff,
  output reg  [3:0] switchingMode_ff,
  output reg        sleepStateSelect_ff,
  output reg        regulatorOn_ff,
  output reg        currentLimitSelect_ff,
  output reg  [1:0] switchingFreqSelect_ff,
  output reg  [1:0] phaseClockSelect_ff,
  output reg  [1:0] voltageScalingSpeed_ff
);
  reg        rangeHigh_ff;
  reg        rangeArm_ff;
  wire [5:0] normStored;
  wire [5:0] normApplied;
  wire [5:0] stbyStored;
  wire [5:0] stbyApplied;
  wire [5:0] slpStored;
  wire [5:0] slpApplied;
  wire [3:0] modeSel;
  wire       sleepSel;
  wire [7:0] cfgVal;
  reg  [7:0] nxt_rdData;
  reg        nxt_hit;
  reg  [5:0] nxt_applied;
  wire       wrNorm;
  wire       wrStby;
  wire       wrSlp;
  wire       wrMode;
  wire       wrCfg;

  assign wrNorm = regWr && (regAddr == `ADDR_NORMAL); // [R18]
  assign wrStby = regWr && (regAddr == `ADDR_STANDBY); // [R18]
  assign wrSlp  = regWr && (regAddr == `ADDR_SLEEP); // [R18]
  assign wrMode = regWr && (regAddr == `ADDR_MODE); // [R18]
  assign wrCfg  = regWr && (regAddr == `ADDR_CONFIG); // [R18]

  // strap captured once after reset release; range is fixed at run time
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      rangeHigh_ff <= `RST_BIT;
      rangeArm_ff  <= 1'b1;
    end else if (rangeArm_ff) begin
      rangeHigh_ff <= rangeOtp; // [R2]
      rangeArm_ff  <= 1'b0;
    end
  end

  setpoint_slot uNorm (
    .clk        (clk),
    .sys_rst    (sys_rst),
    .wrEn       (wrNorm), // [R1]
    .wrData     (regWrData[`SP_MSB:0]),
    .rangeHigh  (rangeHigh_ff),
    .stored_ff  (normStored),
    .applied_ff (normApplied)
  );
  setpoint_slot uStby (
    .clk        (clk),
    .sys_rst    (sys_rst),
    .wrEn       (wrStby), // [R3]
    .wrData     (regWrData[`SP_MSB:0]),
    .rangeHigh  (rangeHigh_ff),
    .stored_ff  (stbyStored),
    .applied_ff (stbyApplied)
  );
  setpoint_slot uSlp (
    .clk        (clk),
    .sys_rst    (sys_rst),
    .wrEn       (wrSlp), // [R5]
    .wrData     (regWrData[`SP_MSB:0]),
    .rangeHigh  (rangeHigh_ff),
    .stored_ff  (slpStored),
    .applied_ff (slpApplied)
  );
  cfg_slot #(.WIDTH(4), .RESET_VALUE(`RST_MODE)) uMode (
    .clk      (clk),
    .sys_rst  (sys_rst),
    .wrEn     (wrMode), // [R8]
    .wrData   (regWrData[`MODE_MSB:0]),
    .value_ff (modeSel)
  );
  cfg_slot #(.WIDTH(1), .RESET_VALUE(`RST_BIT)) uSleepSel (
    .clk      (clk),
    .sys_rst  (sys_rst),
    .wrEn     (wrMode), // [R9]
    .wrData   (regWrData[`SLEEP_STATE_BIT]),
    .value_ff (sleepSel)
  );
  // all eight bits stored, bit 1 included though it drives nothing
  cfg_slot #(.WIDTH(8), .RESET_VALUE(`RST_CONFIG)) uCfg (
    .clk      (clk),
    .sys_rst  (sys_rst),
    .wrEn     (wrCfg), // [R10] [R11] [R12] [R13] [R14]
    .wrData   (regWrData),
    .value_ff (cfgVal)
  );

  always @* begin
    nxt_rdData = 8'h00;
    nxt_hit    = 1'b1;
    case (regAddr)
      `ADDR_NORMAL:  nxt_rdData = {1'b0, rangeHigh_ff, normStored}; // [R2] [R7]
      `ADDR_STANDBY: nxt_rdData = {1'b0, rangeHigh_ff, stbyStored}; // [R4] [R7]
      `ADDR_SLEEP:   nxt_rdData = {1'b0, rangeHigh_ff, slpStored}; // [R6] [R7]
      `ADDR_MODE:    nxt_rdData = {2'b00, sleepSel, 1'b0, modeSel};
      `ADDR_CONFIG:  nxt_rdData = cfgVal; // [R14]
      default:       nxt_hit    = 1'b0;
    endcase
  end

  always @* begin
    case (opState)
      `STATE_STANDBY: nxt_applied = stbyApplied; // [R19]
      `STATE_SLEEP:   nxt_applied = slpApplied; // [R19]
      default:        nxt_applied = normApplied; // [R19]
    endcase
  end

  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      regRdData_ff           <= 8'h00;
      regHit_ff              <= 1'b0;
      targetCode_ff          <= 7'h00;
      switchingMode_ff       <= `RST_MODE;
      sleepStateSelect_ff    <= `RST_BIT;
      regulatorOn_ff         <= 1'b0;
      currentLimitSelect_ff  <= `RST_BIT;
      switchingFreqSelect_ff <= 2'h0;
      phaseClockSelect_ff    <= 2'h0;
      voltageScalingSpeed_ff <= 2'h0;
    end else begin
      if (regRd) begin
        regRdData_ff <= nxt_rdData;
        regHit_ff    <= nxt_hit;
      end
      targetCode_ff          <= {rangeHigh_ff, nxt_applied}; // [R15] [R17]
      switchingMode_ff       <= modeSel; // [R8]
      sleepStateSelect_ff    <= sleepSel; // [R9]
      // sleep with the state bit clear turns the channel off
      regulatorOn_ff         <= (opState != `STATE_SLEEP) || sleepSel; // [R9]
      currentLimitSelect_ff  <= cfgVal[0]; // [R10]
      switchingFreqSelect_ff <= cfgVal[3:2]; // [R11]
      phaseClockSelect_ff    <= cfgVal[5:4]; // [R12]
      voltageScalingSpeed_ff <= cfgVal[7:6]; // [R13]
    end
  end
endmodule
`default_nettype wire

// ===== tb/host_model.sv
// host model driving the register strobes
`timescale 1ns/10ps
`default_nettype none
module host_model (
  input  wire logic       clk,
  input  wire logic [7:0] regRdData_ff,
  output var  logic       regWr,
  output var  logic       regRd,
  output var  logic [7:0] regAddr,
  output var  logic [7:0] regWrData
);
  initial begin
    regWr = 1'b0;
    regRd = 1'b0;
    regAddr = 8'h00;
    regWrData = 8'h00;
  end
  // idle bus shows inverted values so stale data never helps
  task automatic access(input logic wr, input logic [7:0] a, input logic [7:0] d,
                        output logic [7:0] q);
    @(posedge clk);
    regWr <= wr;
    regRd <= !wr;
    regAddr <= a;
    regWrData <= d;
    @(posedge clk);
    regWr <= 1'b0;
    regRd <= 1'b0;
    regAddr <= ~a;
    regWrData <= ~d;
    #1 q = regRdData_ff;
  endtask
endmodule
`default_nettype wire

// ===== tb/buck_regs_assertions.sv
// port checker for the buck channel register bank
`timescale 1ns/10ps
`default_nettype none
module buck_regs_checker (
  input wire logic       clk,
  input wire logic       sys_rst,
  input wire logic       rangeOtp,
  input wire logic [1:0] opState,
  input wire logic       regWr,
  input wire logic       regRd,
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWrData,
  input wire logic [7:0] regRdData_ff,
  input wire logic       regHit_ff,
  input wire logic [3:0] switchingMode_ff,
  input wire logic       sleepStateSelect_ff,
  input wire logic       regulatorOn_ff,
  input wire logic       currentLimitSelect_ff,
  input wire logic [1:0] switchingFreqSelect_ff,
  input wire logic [1:0] phaseClockSelect_ff,
  input wire logic [1:0] voltageScalingSpeed_ff
);
  wire logic mapped = regAddr inside {[8'h35:8'h39]};
  default clocking @(posedge clk);
  endclocking
  default disable iff (sys_rst);
  sequence modeWr;
    regWr && regAddr == 8'h38;
  endsequence
  sequence cfgWr;
    regWr && regAddr == 8'h39;
  endsequence
  sequence spRd;
    regRd && regAddr inside {[8'h35:8'h37]};
  endsequence
  property modeApply;
    logic [7:0] d;
    // storage flop then output flop: new value is sampled from the second edge on, checked on the third
    (modeWr, d = regWrData) |-> ##3 switchingMode_ff == d[3:0] && sleepStateSelect_ff == d[5];
  endproperty
  property cfgApply;
    logic [7:0] d;
    (cfgWr, d = regWrData) |-> ##3 currentLimitSelect_ff == d[0] &&
      {voltageScalingSpeed_ff, phaseClockSelect_ff, switchingFreqSelect_ff} == d[7:2];
  endproperty
  unmapped_read_a: assert property (regRd && !mapped |=> regRdData_ff == 8'h00 && !regHit_ff)
    else $error("unmapped read gave data");
  mapped_hit_a: assert property (regRd && mapped |=> regHit_ff)
    else $error("mapped read not flagged");
  setpoint_bit7_a: assert property (spRd |=> regRdData_ff[7] == 1'b0)
    else $error("set point bit 7 not zero");
  range_mirror_a: assert property (spRd |=> regRdData_ff[6] == rangeOtp)
    else $error("range bit differs from factory bit");
  mode_apply_a: assert property (modeApply)
    else $error("mode outputs did not follow write");
  cfg_apply_a: assert property (cfgApply)
    else $error("config outputs did not follow write");
  mode_unused_a: assert property (regRd && regAddr == 8'h38 |=> regRdData_ff[7:6] == 2'b00
    && !regRdData_ff[4])
    else $error("unused mode bits read nonzero");
  sleep_off_a: assert property ((opState == 2'h2 && !sleepStateSelect_ff)[*3] |-> !regulatorOn_ff)
    else $error("regulator on in sleep with off selected");
endmodule
bind buck_channel_setpoint_regs buck_regs_checker u_chk (.clk, .sys_rst, .rangeOtp, .opState,
  .regWr, .regRd, .regAddr, .regWrData, .regRdData_ff, .regHit_ff, .switchingMode_ff,
  .sleepStateSelect_ff, .regulatorOn_ff, .currentLimitSelect_ff, .switchingFreqSelect_ff,
  .phaseClockSelect_ff, .voltageScalingSpeed_ff);
`default_nettype wire

// ===== tb/tb.sv
// self-checking bench for the buck channel register bank
`timescale 1ns/10ps
`default_nettype none
module tb;
  logic       clk = 1'b0;
  logic       sys_rst = 1'b1;
  logic       rangeOtp = 1'b1;
  logic [1:0] opState = 2'h0;
  logic       regWr, regRd, regHit_ff, sleepOn, regulatorOn_ff, ilim;
  logic [7:0] regAddr, regWrData, regRdData_ff, q;
  logic [6:0] target;
  logic [3:0] mode;
  logic [1:0] freq, phase, dvs;
  int         failures = 0;
  int         n_compared = 0;
  always #12.5 clk = ~clk;
  buck_channel_setpoint_regs u_dut (.clk, .sys_rst, .rangeOtp, .opState, .regWr, .regRd,
    .regAddr, .regWrData, .regRdData_ff, .regHit_ff, .targetCode_ff(target),
    .switchingMode_ff(mode), .sleepStateSelect_ff(sleepOn), .regulatorOn_ff,
    .currentLimitSelect_ff(ilim), .switchingFreqSelect_ff(freq),
    .phaseClockSelect_ff(phase), .voltageScalingSpeed_ff(dvs));
  host_model u_host (.clk, .regRdData_ff, .regWr, .regRd, .regAddr, .regWrData);
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      failures++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    u_host.access(1'b1, a, d, q);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    u_host.access(1'b0, a, 8'h00, q);
    chk(q, e);
  endtask
  // range bit is latched only once after reset
  task automatic do_reset(input logic r);
    @(posedge clk);
    sys_rst <= 1'b1;
    rangeOtp <= r;
    repeat (3) @(posedge clk);
    sys_rst <= 1'b0;
    repeat (2) @(posedge clk);
  endtask
  task automatic set_state(input logic [1:0] s);
    @(posedge clk);
    opState <= s;
    repeat (2) @(posedge clk);
    #1;
  endtask
  task automatic reset_values;
    rd(8'h35, 8'h40);
    rd(8'h36, 8'h40);
    rd(8'h37, 8'h40);
    rd(8'h38, 8'h08);
    rd(8'h39, 8'h00);
    rd(8'h3A, 8'h00);
    chk({7'h00, regHit_ff}, 8'h00);
  endtask
  task automatic rw_fields;
    logic [7:0] m [5] = '{8'h3F, 8'h3F, 8'h3F, 8'h2F, 8'hFF};
    logic [7:0] f [5] = '{8'h40, 8'h40, 8'h40, 8'h00, 8'h00};
    foreach (m[i]) begin
      wr(8'(8'h35 + i), 8'hFF);
      rd(8'(8'h35 + i), m[i] | f[i]);
      wr(8'(8'h35 + i), 8'h5A);
      rd(8'(8'h35 + i), (8'h5A & m[i]) | f[i]);
    end
    chk({4'h0, mode}, 8'h0A);
    chk({dvs, phase, freq, 1'b0, ilim}, 8'h58);
  endtask
  task automatic state_targets;
    wr(8'h35, 8'h20);
    wr(8'h36, 8'h32);
    wr(8'h37, 8'h33);
    wr(8'h38, 8'h08);
    set_state(2'h0);
    chk({1'b0, target}, 8'h60);
    set_state(2'h1);
    chk({1'b0, target}, 8'h72);
    set_state(2'h2);
    chk({1'b0, target}, 8'h5A);
    chk({7'h00, regulatorOn_ff}, 8'h00);
    rd(8'h37, 8'h73);
    wr(8'h38, 8'h28);
    set_state(2'h2);
    chk({7'h00, regulatorOn_ff}, 8'h01);
  endtask
  task automatic low_range;
    do_reset(1'b0);
    rd(8'h36, 8'h00);
    wr(8'h35, 8'h08);
    set_state(2'h0);
    chk({1'b0, target}, 8'h00);
    wr(8'h35, 8'h09);
    set_state(2'h0);
    chk({1'b0, target}, 8'h09);
    wr(8'h35, 8'h28);
    wr(8'h35, 8'h08);
    set_state(2'h0);
    chk({1'b0, target}, 8'h28);
  endtask
  task automatic tally_and_finish;
    $display("compared %0d mismatches %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  initial begin
    do_reset(1'b1);
    reset_values();
    rw_fields();
    state_targets();
    low_range();
    tally_and_finish();
  end
endmodule
`default_nettype wire
